/* File: rtl/eatf_decoder.sv */
/*
  Explicit address transmit frame decoder: parses host frames byte by byte,
  checks them, publishes the decoded request, a status request and the payload.
  Assumes a Wishbone classic master and a byte source with valid/ready.
*/
`default_nettype none
module eatf_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host frame bytes
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Decoded request
  output var eatf_pkg::eatf_req_t req,
  output logic req_valid,
  // Status response request
  output var eatf_pkg::eatf_status_t status,
  output logic status_valid,
  // Payload stream
  output var eatf_pkg::eatf_pl_t pl,
  output logic pl_valid,
  input wire logic pl_ready
);
  eatf_pkg::eatf_state_t state_reg;
  eatf_pkg::eatf_err_t err_reg;
  eatf_pkg::eatf_err_t final_err;
  logic [15:0] pos_reg;
  logic [15:0] len_reg;
  logic [7:0] sum_reg;
  logic [15:0] pcnt_reg;
  logic [15:0] rd_cnt_reg;
  logic [7:0] fid_reg;
  logic [63:0] dest64_reg;
  logic [15:0] dest16_reg;
  logic [7:0] src_ep_reg;
  logic [7:0] dst_ep_reg;
  logic [15:0] cluster_reg;
  logic [15:0] profile_reg;
  logic [7:0] radius_reg;
  logic [7:0] opt_reg;
  logic variant_reg;
  logic [7:0] max_hops_reg;
  logic [7:0] def_opts_reg;
  logic [7:0] max_pl_reg;
  logic [15:0] good_cnt_reg;
  logic [15:0] bad_cnt_reg;
  logic [7:0] last_fid_reg;
  eatf_pkg::eatf_err_t last_err_reg;
  logic pl_last_reg;
  logic [7:0] mem_q;
  logic rx_acc;
  logic rd_en;
  logic wr_en;
  logic wb_req;
  logic [7:0] csum_total;
  logic [7:0] opt_eff;
  logic [7:0] pl_limit;
  logic bcast;
  logic [7:0] src_eff;
  logic [7:0] dst_eff;
  logic data_ep;

  function automatic logic [7:0] map_ep(input logic [7:0] ep, input logic variant);
    if (variant && (ep < eatf_pkg::EP_RES_LO || ep > eatf_pkg::EP_RES_HI)) begin
      return eatf_pkg::EP_DATA;
    end
    return ep;
  endfunction

  function automatic eatf_pkg::eatf_ep_class_t class_ep(input logic [7:0] ep);
    if (ep == eatf_pkg::EP_DATA) begin
      return eatf_pkg::EPC_DATA;
    end else if (ep == eatf_pkg::EP_DEVOBJ) begin
      return eatf_pkg::EPC_DEVOBJ;
    end else if (ep == eatf_pkg::EP_SS_SERVER || ep == eatf_pkg::EP_SS_CLIENT || ep == eatf_pkg::EP_SS_AUTH) begin
      return eatf_pkg::EPC_SECURE;
    end
    return eatf_pkg::EPC_OTHER;
  endfunction

  // Input stalls only while the payload drains
  assign rx_ready = (state_reg != eatf_pkg::ST_DRAIN);
  assign rx_acc = rx_valid && rx_ready;
  assign csum_total = sum_reg + rx_data;
  assign opt_eff = ((opt_reg == 8'h00) ? def_opts_reg : opt_reg) & eatf_pkg::OPT_USED_MASK;
  assign bcast = (dest64_reg == eatf_pkg::BCAST64);
  assign src_eff = map_ep(src_ep_reg, variant_reg);
  assign dst_eff = map_ep(dst_ep_reg, variant_reg);
  assign data_ep = (dst_eff == eatf_pkg::EP_DATA);

  // Secure sessions shrink the allowed payload
  always_comb begin
    if (!opt_eff[eatf_pkg::OPT_SECURE_BIT]) begin
      pl_limit = max_pl_reg;
    end else if (max_pl_reg > eatf_pkg::SECURE_REDUCE) begin
      pl_limit = max_pl_reg - eatf_pkg::SECURE_REDUCE;
    end else begin
      pl_limit = 8'h00;
    end
  end

  // Verdict at the checksum byte
  always_comb begin
    if (err_reg != eatf_pkg::ERR_NONE) begin
      final_err = err_reg;
    end else if (csum_total != eatf_pkg::CSUM_GOOD) begin
      final_err = eatf_pkg::ERR_CSUM;
    end else if (pcnt_reg > {8'h00, pl_limit}) begin
      final_err = eatf_pkg::ERR_PAYLOAD;
    end else begin
      final_err = eatf_pkg::ERR_NONE;
    end
  end

  // Frame sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= eatf_pkg::ST_HUNT;
      pos_reg <= 16'h0000;
      len_reg <= 16'h0000;
    end else begin
      case (state_reg)
        eatf_pkg::ST_HUNT: begin
          if (rx_acc && rx_data == eatf_pkg::DELIM) begin
            state_reg <= eatf_pkg::ST_LEN_HI;
          end
        end
        eatf_pkg::ST_LEN_HI: begin
          if (rx_acc) begin
            len_reg <= {rx_data, 8'h00};
            state_reg <= eatf_pkg::ST_LEN_LO;
          end
        end
        eatf_pkg::ST_LEN_LO: begin
          if (rx_acc) begin
            len_reg <= {len_reg[15:8], rx_data};
            pos_reg <= eatf_pkg::OFF_TYPE;
            state_reg <= ({len_reg[15:8], rx_data} == 16'h0000) ? eatf_pkg::ST_CSUM : eatf_pkg::ST_BODY;
          end
        end
        eatf_pkg::ST_BODY: begin
          if (rx_acc) begin
            pos_reg <= pos_reg + 16'h0001;
            if (pos_reg == len_reg + 16'h0002) begin
              state_reg <= eatf_pkg::ST_CSUM;
            end
          end
        end
        eatf_pkg::ST_CSUM: begin
          if (rx_acc) begin
            state_reg <= (final_err == eatf_pkg::ERR_NONE && pcnt_reg != 16'h0000) ?
              eatf_pkg::ST_DRAIN : eatf_pkg::ST_HUNT;
          end
        end
        eatf_pkg::ST_DRAIN: begin
          if (pl_valid && pl_ready && pl_last_reg) begin
            state_reg <= eatf_pkg::ST_HUNT;
          end
        end
        default: begin
          state_reg <= eatf_pkg::ST_HUNT;
        end
      endcase
    end
  end

  // Field capture, checksum and error tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg <= 8'h00;
      err_reg <= eatf_pkg::ERR_NONE;
      pcnt_reg <= 16'h0000;
      fid_reg <= 8'h00;
      dest64_reg <= 64'h0000_0000_0000_0000;
      dest16_reg <= eatf_pkg::ADDR16_UNKNOWN;
      src_ep_reg <= 8'h00;
      dst_ep_reg <= 8'h00;
      cluster_reg <= 16'h0000;
      profile_reg <= 16'h0000;
      radius_reg <= 8'h00;
      opt_reg <= 8'h00;
    end else if (rx_acc && state_reg == eatf_pkg::ST_LEN_LO) begin
      sum_reg <= 8'h00;
      pcnt_reg <= 16'h0000;
      err_reg <= ({len_reg[15:8], rx_data} < eatf_pkg::MIN_LEN) ? eatf_pkg::ERR_SHORT : eatf_pkg::ERR_NONE;
    end else if (rx_acc && state_reg == eatf_pkg::ST_BODY) begin
      sum_reg <= csum_total;
      if (pos_reg == eatf_pkg::OFF_TYPE) begin
        if (rx_data != eatf_pkg::TYPE_EXPLICIT && err_reg == eatf_pkg::ERR_NONE) begin
          err_reg <= eatf_pkg::ERR_TYPE;
        end
      end else if (pos_reg == eatf_pkg::OFF_FID) begin
        fid_reg <= rx_data;
      end else if (pos_reg < eatf_pkg::OFF_DEST16) begin
        dest64_reg <= {dest64_reg[55:0], rx_data};
      end else if (pos_reg < eatf_pkg::OFF_SRC_EP) begin
        dest16_reg <= {dest16_reg[7:0], rx_data};
      end else if (pos_reg == eatf_pkg::OFF_SRC_EP) begin
        src_ep_reg <= rx_data;
      end else if (pos_reg == eatf_pkg::OFF_DST_EP) begin
        dst_ep_reg <= rx_data;
      end else if (pos_reg < eatf_pkg::OFF_PROFILE) begin
        cluster_reg <= {cluster_reg[7:0], rx_data};
      end else if (pos_reg < eatf_pkg::OFF_RADIUS) begin
        profile_reg <= {profile_reg[7:0], rx_data};
      end else if (pos_reg == eatf_pkg::OFF_RADIUS) begin
        radius_reg <= rx_data;
      end else if (pos_reg == eatf_pkg::OFF_OPTIONS) begin
        opt_reg <= rx_data;
      end else begin
        pcnt_reg <= pcnt_reg + 16'h0001;
      end
    end
  end

  // Payload bytes beyond the store are counted but not kept
  assign wr_en = rx_acc && state_reg == eatf_pkg::ST_BODY && pos_reg >= eatf_pkg::OFF_PAYLOAD &&
    pcnt_reg < 16'(eatf_pkg::MEM_DEPTH);

  // Decoded request and status publication
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
      req_valid <= 1'b0;
      status <= '0;
      status_valid <= 1'b0;
    end else begin
      req_valid <= 1'b0;
      status_valid <= 1'b0;
      if (rx_acc && state_reg == eatf_pkg::ST_CSUM && final_err == eatf_pkg::ERR_NONE) begin
        req_valid <= 1'b1;
        req.frame_id <= fid_reg;
        req.dest64 <= dest64_reg;
        req.dest16 <= dest16_reg;
        req.src_ep <= src_eff;
        req.dst_ep <= dst_eff;
        req.cluster <= cluster_reg;
        req.profile <= profile_reg;
        req.radius <= bcast ? ((radius_reg == 8'h00) ? max_hops_reg : radius_reg) : 8'h00;
        req.options <= opt_eff;
        req.payload_len <= pcnt_reg;
        req.broadcast <= bcast;
        req.no_ack <= opt_eff[eatf_pkg::OPT_NO_ACK_BIT];
        req.all_pans <= opt_eff[eatf_pkg::OPT_ALL_PAN_BIT];
        req.secure <= opt_eff[eatf_pkg::OPT_SECURE_BIT];
        req.transparent <= data_ep && cluster_reg == eatf_pkg::CL_TRANSPARENT;
        req.loopback <= data_ep && cluster_reg == eatf_pkg::CL_LOOPBACK && !variant_reg;
        req.native_profile <= profile_reg == eatf_pkg::PROF_NATIVE || profile_reg == eatf_pkg::PROF_DEVICE;
        req.ep_class <= class_ep(dst_eff);
        if (fid_reg != 8'h00) begin
          status_valid <= 1'b1;
          status.frame_id <= fid_reg;
          status.frame_type <= eatf_pkg::STATUS_TYPE;
        end
      end
    end
  end

  // Frame statistics
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      good_cnt_reg <= 16'h0000;
      bad_cnt_reg <= 16'h0000;
      last_fid_reg <= 8'h00;
      last_err_reg <= eatf_pkg::ERR_NONE;
    end else if (rx_acc && state_reg == eatf_pkg::ST_CSUM) begin
      last_fid_reg <= fid_reg;
      last_err_reg <= final_err;
      if (final_err == eatf_pkg::ERR_NONE) begin
        good_cnt_reg <= good_cnt_reg + 16'h0001;
      end else begin
        bad_cnt_reg <= bad_cnt_reg + 16'h0001;
      end
    end
  end

  // Payload drain from the store
  assign rd_en = state_reg == eatf_pkg::ST_DRAIN && rd_cnt_reg < req.payload_len && (!pl_valid || pl_ready);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt_reg <= 16'h0000;
      pl_valid <= 1'b0;
      pl_last_reg <= 1'b0;
    end else if (state_reg != eatf_pkg::ST_DRAIN) begin
      rd_cnt_reg <= 16'h0000;
      pl_valid <= 1'b0;
      pl_last_reg <= 1'b0;
    end else if (rd_en) begin
      rd_cnt_reg <= rd_cnt_reg + 16'h0001;
      pl_valid <= 1'b1;
      pl_last_reg <= (rd_cnt_reg + 16'h0001 == req.payload_len);
    end else if (pl_ready) begin
      pl_valid <= 1'b0;
    end
  end

  assign pl = {mem_q, pl_last_reg};

  eatf_payload_mem u_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_addr(pcnt_reg[eatf_pkg::MEM_AW-1:0]),
    .wr_data(rx_data),
    .rd_en(rd_en),
    .rd_addr(rd_cnt_reg[eatf_pkg::MEM_AW-1:0]),
    .rd_data(mem_q)
  );

  // Wishbone slave, one wait state per access
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      variant_reg <= eatf_pkg::CTRL_VARIANT_RST;
      max_hops_reg <= eatf_pkg::MAX_HOPS_RST;
      def_opts_reg <= eatf_pkg::DEF_OPTS_RST;
      max_pl_reg <= eatf_pkg::MAX_PAYLOAD_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == eatf_pkg::REG_CTRL) begin
        variant_reg <= wb_dat_i[eatf_pkg::CTRL_VARIANT_BIT];
      end else if (wb_adr_i == eatf_pkg::REG_MAX_HOPS) begin
        max_hops_reg <= wb_dat_i[7:0];
      end else if (wb_adr_i == eatf_pkg::REG_DEF_OPTS) begin
        def_opts_reg <= wb_dat_i[7:0];
      end else if (wb_adr_i == eatf_pkg::REG_MAX_PAYLOAD) begin
        max_pl_reg <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      if (wb_adr_i == eatf_pkg::REG_CTRL) begin
        wb_dat_o <= {31'h0000_0000, variant_reg};
      end else if (wb_adr_i == eatf_pkg::REG_MAX_HOPS) begin
        wb_dat_o <= {24'h00_0000, max_hops_reg};
      end else if (wb_adr_i == eatf_pkg::REG_DEF_OPTS) begin
        wb_dat_o <= {24'h00_0000, def_opts_reg};
      end else if (wb_adr_i == eatf_pkg::REG_MAX_PAYLOAD) begin
        wb_dat_o <= {24'h00_0000, max_pl_reg};
      end else if (wb_adr_i == eatf_pkg::REG_COUNTS) begin
        wb_dat_o <= {bad_cnt_reg, good_cnt_reg};
      end else if (wb_adr_i == eatf_pkg::REG_LAST) begin
        wb_dat_o <= {21'h00_0000, last_err_reg, last_fid_reg};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Checks
  hunt_resync_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == eatf_pkg::ST_HUNT && rx_valid && rx_data == eatf_pkg::DELIM |=> state_reg == eatf_pkg::ST_LEN_HI)
    else $error("delimiter did not start a frame");
  zero_fid_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && req.frame_id == 8'h00 |-> !status_valid)
    else $error("status raised for zero frame id");
  status_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_valid |-> req_valid && status.frame_id == req.frame_id && status.frame_type == eatf_pkg::STATUS_TYPE)
    else $error("status frame id or type wrong");
  type_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_acc && state_reg == eatf_pkg::ST_CSUM && err_reg == eatf_pkg::ERR_TYPE |=> !req_valid && !status_valid)
    else $error("wrong frame type acted on");
  csum_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_acc && state_reg == eatf_pkg::ST_CSUM && csum_total != eatf_pkg::CSUM_GOOD |=> !req_valid ##1 !pl_valid)
    else $error("bad checksum frame acted on");
  ep_map_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && variant_reg && (dst_ep_reg < eatf_pkg::EP_RES_LO || dst_ep_reg > eatf_pkg::EP_RES_HI)
    |-> req.dst_ep == eatf_pkg::EP_DATA)
    else $error("endpoint not mapped to data endpoint");
  loopback_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && $past(variant_reg) |-> !req.loopback)
    else $error("loopback accepted in variant mode");
  radius_default_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && req.broadcast && radius_reg == 8'h00 |-> req.radius == $past(max_hops_reg))
    else $error("radius did not take max hops setting");
  opts_default_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && opt_reg == 8'h00 |-> req.options == ($past(def_opts_reg) & eatf_pkg::OPT_USED_MASK))
    else $error("default options not applied");
  secure_limit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && req.secure |-> req.payload_len == 16'h0000 || req.payload_len + 16'h0004 <= {8'h00, $past(max_pl_reg)})
    else $error("secure payload over reduced limit");
endmodule
`default_nettype wire

/* File: rtl/eatf_payload_mem.sv */
/*
  Payload store: one write port, one read port with registered read data.
  Assumes writer and reader never touch the same entry in one cycle.
*/
`default_nettype none
module eatf_payload_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [eatf_pkg::MEM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [eatf_pkg::MEM_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [eatf_pkg::MEM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data holds while the reader stalls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: shared/eatf_pkg.sv */
/*
  Constants, field layouts and carrier types for the explicit address
  transmit frame decoder.
  Assumes byte-wide host frames, most significant byte first in outer fields.
*/
`default_nettype none
package eatf_pkg;
  // Frame codes
  localparam logic [7:0] DELIM = 8'h7e;
  localparam logic [7:0] TYPE_EXPLICIT = 8'h11;
  localparam logic [7:0] STATUS_TYPE = 8'h8b;
  localparam logic [7:0] CSUM_GOOD = 8'hff;
  // Byte offsets within the frame
  localparam logic [15:0] OFF_TYPE = 16'h0003;
  localparam logic [15:0] OFF_FID = 16'h0004;
  localparam logic [15:0] OFF_DEST64 = 16'h0005;
  localparam logic [15:0] OFF_DEST16 = 16'h000d;
  localparam logic [15:0] OFF_SRC_EP = 16'h000f;
  localparam logic [15:0] OFF_DST_EP = 16'h0010;
  localparam logic [15:0] OFF_CLUSTER = 16'h0011;
  localparam logic [15:0] OFF_PROFILE = 16'h0013;
  localparam logic [15:0] OFF_RADIUS = 16'h0015;
  localparam logic [15:0] OFF_OPTIONS = 16'h0016;
  localparam logic [15:0] OFF_PAYLOAD = 16'h0017;
  // Header bytes from type through options
  localparam logic [15:0] MIN_LEN = 16'h0014;
  // Addressing
  localparam logic [63:0] BCAST64 = 64'h0000_0000_0000_ffff;
  localparam logic [15:0] ADDR16_UNKNOWN = 16'hfffe;
  // Endpoints
  localparam logic [7:0] EP_RES_LO = 8'hdc;
  localparam logic [7:0] EP_RES_HI = 8'hee;
  localparam logic [7:0] EP_DATA = 8'he8;
  localparam logic [7:0] EP_DEVOBJ = 8'he6;
  localparam logic [7:0] EP_SS_SERVER = 8'he5;
  localparam logic [7:0] EP_SS_CLIENT = 8'he4;
  localparam logic [7:0] EP_SS_AUTH = 8'he3;
  // Clusters and profiles
  localparam logic [15:0] CL_TRANSPARENT = 16'h0011;
  localparam logic [15:0] CL_LOOPBACK = 16'h0012;
  localparam logic [15:0] PROF_NATIVE = 16'hc105;
  localparam logic [15:0] PROF_DEVICE = 16'h0000;
  // Transmit option bits
  localparam int OPT_NO_ACK_BIT = 0;
  localparam int OPT_ALL_PAN_BIT = 1;
  localparam int OPT_SECURE_BIT = 4;
  localparam logic [7:0] OPT_USED_MASK = 8'h13;
  localparam logic [7:0] SECURE_REDUCE = 8'h04;
  // Payload store
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MAX_HOPS = 8'h04;
  localparam logic [7:0] REG_DEF_OPTS = 8'h08;
  localparam logic [7:0] REG_MAX_PAYLOAD = 8'h0c;
  localparam logic [7:0] REG_COUNTS = 8'h10;
  localparam logic [7:0] REG_LAST = 8'h14;
  // Register fields and reset values
  localparam int CTRL_VARIANT_BIT = 0;
  localparam logic CTRL_VARIANT_RST = 1'b0;
  localparam logic [7:0] MAX_HOPS_RST = 8'h00;
  localparam logic [7:0] DEF_OPTS_RST = 8'h00;
  localparam logic [7:0] MAX_PAYLOAD_RST = 8'hff;

  typedef enum logic [2:0] {ST_HUNT, ST_LEN_HI, ST_LEN_LO, ST_BODY, ST_CSUM, ST_DRAIN} eatf_state_t;
  typedef enum logic [1:0] {EPC_OTHER, EPC_DATA, EPC_DEVOBJ, EPC_SECURE} eatf_ep_class_t;
  typedef enum logic [2:0] {ERR_NONE, ERR_TYPE, ERR_SHORT, ERR_CSUM, ERR_PAYLOAD} eatf_err_t;

  typedef struct packed {
    logic [7:0] frame_id;
    logic [63:0] dest64;
    logic [15:0] dest16;
    logic [7:0] src_ep;
    logic [7:0] dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic [7:0] radius;
    logic [7:0] options;
    logic [15:0] payload_len;
    logic broadcast;
    logic no_ack;
    logic all_pans;
    logic secure;
    logic transparent;
    logic loopback;
    logic native_profile;
    eatf_ep_class_t ep_class;
  } eatf_req_t;

  typedef struct packed {
    logic [7:0] frame_type;
    logic [7:0] frame_id;
  } eatf_status_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } eatf_pl_t;
endpackage
`default_nettype wire

/* File: test/eatf_host_model.sv */
/*
  Host model: frames a body with delimiter, length and checksum.
  Assumes rx_ready is sampled at the rising edge.
*/
`default_nettype none
module eatf_host_model (
  // Clock
  input wire logic core_clk,
  // Frame bytes
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [7:0] s;
    logic [15:0] n;
    logic [7:0] q[$];
    s = 8'h00;
    n = 16'(f.size());
    foreach (f[i]) s += f[i];
    q = {8'h7e, n[15:8], n[7:0], f, (8'hff - s) ^ {7'h00, bad}};
    rx_valid <= 1'b1;
    foreach (q[i]) begin
      rx_data <= q[i];
      do @(posedge core_clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    // Released line shows the inverse, not a stale byte
    rx_data <= ~q[q.size()-1];
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
/*
  Bench for the frame decoder: host model sends frames, Wishbone sets config.
  Assumes the hand-over timing and register map of the decoder.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pl_ready = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, rx_data;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_ack_o, rx_valid, rx_ready, req_valid, status_valid, pl_valid;
  eatf_pkg::eatf_req_t req;
  eatf_pkg::eatf_status_t status;
  eatf_pkg::eatf_pl_t pl;
  eatf_pkg::eatf_pl_t pq[$];
  logic [7:0] f[$];
  int mismatches = 0, cmp_count = 0, cyc = 0;
  logic [15:0] nreq = 16'h0000, nst = 16'h0000;
  always #12.5 core_clk = ~core_clk;
  eatf_decoder DUT (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .req(req),
    .req_valid(req_valid), .status(status), .status_valid(status_valid), .pl(pl), .pl_valid(pl_valid),
    .pl_ready(pl_ready));
  eatf_host_model host (.core_clk(core_clk), .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  // Stalling payload sink, pulse counters, hang limit
  always @(posedge core_clk) begin
    pl_ready <= ~pl_ready;
    cyc++;
    if (req_valid === 1'b1) nreq++;
    if (status_valid === 1'b1) nst++;
    if (pl_valid === 1'b1 && pl_ready === 1'b1) pq.push_back(pl);
    if (cyc == 4000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input logic [63:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h1;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic mk(input logic [7:0] ty, fid, input logic [63:0] d, input logic [7:0] ep,
    input logic [15:0] cl, input logic [7:0] opt, input logic bad);
    f = {ty, fid};
    for (int i = 7; i >= 0; i--) f.push_back(d[i*8+:8]);
    f = {f, 8'hff, 8'hfe, 8'he8, ep, cl[15:8], cl[7:0], 8'hc1, 8'h05, 8'h00, opt, 8'h54, 8'h78};
    host.send(f, bad);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_good();
    wb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'hff);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    mk(8'h11, 8'h87, 64'h0013a20012345678, 8'he8, 16'h0011, 8'h00, 1'b0);
    chk({nreq, nst, status}, {16'd1, 16'd1, 16'h8b87});
    chk({req.options, req.no_ack, req.transparent, req.native_profile, req.radius}, 19'h00f << 8);
    chk(req.dest64, 64'h0013a20012345678);
    chk(req.dest16, 16'hfffe);
    chk({req.src_ep, req.dst_ep, req.cluster, req.profile}, 48'he8e8_0011_c105);
    chk(req.payload_len, 16'h0002);
    for (int i = 0; i < 40 && pq.size() < 2; i++) @(posedge core_clk);
    chk({pq[0], pq[1]}, 18'h150f1);
    $display("good frame done");
  endtask
  task automatic t_bcast();
    wb(1'b1, 8'h04, 32'h5);
    mk(8'h11, 8'h00, 64'hffff, 8'he6, 16'h0011, 8'h0e, 1'b0);
    chk({nreq, nst}, {16'd2, 16'd1});
    chk({req.radius, req.options, req.broadcast, req.all_pans}, 18'h0140b);
    chk(req.ep_class, eatf_pkg::EPC_DEVOBJ);
    $display("broadcast done");
  endtask
  task automatic t_bad();
    mk(8'h11, 8'h01, 64'hffff, 8'he8, 16'h0011, 8'h00, 1'b1);
    mk(8'h10, 8'h01, 64'hffff, 8'he8, 16'h0011, 8'h00, 1'b0);
    chk({nreq, nst}, {16'd2, 16'd1});
    wb(1'b0, 8'h14, 32'h0);
    chk(q[10:8], 3'h1);
    $display("bad frames done");
  endtask
  task automatic t_secure();
    wb(1'b1, 8'h0c, 32'h5);
    mk(8'h11, 8'h02, 64'hffff, 8'he8, 16'h0011, 8'h10, 1'b0);
    wb(1'b0, 8'h14, 32'h0);
    chk(q[10:8], 3'h4);
    wb(1'b1, 8'h0c, 32'h6);
    mk(8'h11, 8'h02, 64'hffff, 8'he8, 16'h0012, 8'h10, 1'b0);
    chk({nreq, req.secure, req.loopback}, {16'd3, 1'b1, 1'b1});
    $display("secure done");
  endtask
  task automatic t_variant();
    wb(1'b1, 8'h00, 32'h1);
    mk(8'h11, 8'h03, 64'hffff_ffff_ffff_ffff, 8'h42, 16'h0012, 8'h01, 1'b0);
    chk({nreq, nst, req.ep_class, req.loopback}, {16'd4, 16'd3, eatf_pkg::EPC_DATA, 1'b0});
    chk(req.dest64, 64'hffff_ffff_ffff_ffff);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0003_0004);
    $display("variant done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_good();
    t_bcast();
    t_bad();
    t_secure();
    t_variant();
    final_report();
  end
endmodule
`default_nettype wire
